// ### logic/core_irq_aggregator.sv
// prioritized interrupt aggregator with fast and normal core outputs
// Notes on behaviour
// - sixty-four request channels 0..63, sixteen of them from outside pins
// - every channel has its own enable bit gating the core outputs
// - each channel goes to either the fast or the normal output
// - eight priority levels: two fast levels, six normal levels
// - equal levels: lowest channel number wins
// - hardware picks one winner per output type, no software dispatch
// - each entry register holds the vector of the most urgent enabled pending channel of its type (disabled ones too in raw mode)
// - software sets table base and entry size for fast and normal tables
// - levels 0 and 1 are fast, 2 to 7 normal, lower more urgent
// - entry = base + (channel+1) * size of 4/8/16/32; base when idle
// - status captures every event; outputs need the enable bit
// - writing one clears a status bit, writing zero does nothing
`timescale 1ns/1ps
module core_irq_aggregator
  import core_irq_aggregator_pkg::*;
(
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rstn,
  // peripheral event lines, a high level captures the event
  input  wire logic [core_irq_aggregator_pkg::NUM_CH-1:0] event_in,
  // register port
  input  wire logic [core_irq_aggregator_pkg::ADDR_W-1:0] addr,
  input  wire logic [core_irq_aggregator_pkg::DATA_W-1:0] wdata,
  input  wire logic                              wr,
  input  wire logic                              rd,
  output logic [core_irq_aggregator_pkg::DATA_W-1:0]      rdata,
  // core side
  output logic                                   fast_interrupt,
  output logic                                   normal_interrupt,
  output logic [core_irq_aggregator_pkg::DATA_W-1:0]      fast_vector_address,
  output logic [core_irq_aggregator_pkg::DATA_W-1:0]      normal_vector_address
);
  import core_irq_aggregator_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0]             pend;
    logic [NUM_CH-1:0]             chen;
    logic [NUM_CH-1:0]             held;
    logic [NUM_CH-1:0][PRIO_W-1:0] prio;
    logic [DATA_W-1:0]             base;
    logic [SIZE_W-1:0]             size;
    logic                          idmode;
    logic                          fraw;
    logic                          nraw;
    logic                          fout;
    logic                          nout;
    logic [DATA_W-1:0]             fentry;
    logic [DATA_W-1:0]             nentry;
    logic [DATA_W-1:0]             rdata;
  } state_t;

  localparam state_t STATE_RST = '0;

  state_t            s_q;
  state_t            s_d;
  logic [NUM_CH-1:0] fast_ch;
  logic [NUM_CH-1:0] eff_en;
  logic [NUM_CH-1:0] f_req;
  logic [NUM_CH-1:0] n_req;
  logic              f_valid;
  logic              n_valid;
  logic [IDX_W-1:0]  f_idx;
  logic [IDX_W-1:0]  n_idx;
  logic [PRIO_W-1:0] f_lvl;
  logic [PRIO_W-1:0] n_lvl;
  logic [DATA_W-1:0] f_entry_c;
  logic [DATA_W-1:0] n_entry_c;
  logic [DATA_W-1:0] f_ofs;
  logic [DATA_W-1:0] n_ofs;
  // checker helpers, one bit per channel
  logic [NUM_CH-1:0] f_beat;
  logic [NUM_CH-1:0] n_beat;

  // per-channel routing and effective enable
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign fast_ch[gi] = (s_q.prio[gi] <= LVL_FAST_MAX);
      // delayed mode keeps the enable seen before the event until it is cleared
      assign eff_en[gi]  = s_q.idmode ? s_q.held[gi] : s_q.chen[gi];
      // a request that ought to have beaten the chosen winner
      assign f_beat[gi]  = f_req[gi] && (s_q.prio[gi] < f_lvl ||
                           (s_q.prio[gi] == f_lvl && IDX_W'(gi) < f_idx));
      assign n_beat[gi]  = n_req[gi] && (s_q.prio[gi] < n_lvl ||
                           (s_q.prio[gi] == n_lvl && IDX_W'(gi) < n_idx));
    end
  endgenerate

  // raw mode lets disabled events steer the vector but never the outputs
  assign f_req = s_q.pend & fast_ch & (s_q.fraw ? {NUM_CH{1'b1}} : eff_en);
  assign n_req = s_q.pend & ~fast_ch & (s_q.nraw ? {NUM_CH{1'b1}} : eff_en);

  prio_select #(.N(NUM_CH), .PW(PRIO_W), .IW(IDX_W)) u_fast_sel (
    .req   (f_req),
    .prio  (s_q.prio),
    .valid (f_valid),
    .index (f_idx),
    .level (f_lvl)
  );

  prio_select #(.N(NUM_CH), .PW(PRIO_W), .IW(IDX_W)) u_norm_sel (
    .req   (n_req),
    .prio  (s_q.prio),
    .valid (n_valid),
    .index (n_idx),
    .level (n_lvl)
  );

  // entry address; shift covers 4..32 byte entries
  assign f_ofs     = (DATA_W'(f_idx) + 32'h0000_0001) << (ENTRY_SHIFT_MIN + int'(s_q.size));
  assign n_ofs     = (DATA_W'(n_idx) + 32'h0000_0001) << (ENTRY_SHIFT_MIN + int'(s_q.size));
  assign f_entry_c = f_valid ? s_q.base + f_ofs : s_q.base;
  assign n_entry_c = n_valid ? s_q.base + n_ofs : s_q.base;

  // next state: bus writes, event capture, outputs and read data
  always_comb begin
    logic [NUM_CH-1:0] clr;
    int                pri_reg;
    clr     = '0;
    pri_reg = 0;
    s_d     = s_q;
    if (wr) begin
      unique case (addr)
        OFF_FSTAT0: clr[HALF_CH-1:0]      = wdata & fast_ch[HALF_CH-1:0];
        OFF_FSTAT1: clr[NUM_CH-1:HALF_CH] = wdata & fast_ch[NUM_CH-1:HALF_CH];
        OFF_NSTAT0: clr[HALF_CH-1:0]      = wdata & ~fast_ch[HALF_CH-1:0];
        OFF_NSTAT1: clr[NUM_CH-1:HALF_CH] = wdata & ~fast_ch[NUM_CH-1:HALF_CH];
        OFF_EN0:  s_d.chen[HALF_CH-1:0]      = wdata;
        OFF_EN1:  s_d.chen[NUM_CH-1:HALF_CH] = wdata;
        OFF_CTL: begin
          s_d.idmode = wdata[CTL_IDMODE];
          s_d.fraw   = wdata[CTL_FRAW];
          s_d.nraw   = wdata[CTL_NRAW];
          s_d.size   = wdata[CTL_SIZE +: SIZE_W];
        end
        OFF_BASE: s_d.base = wdata;
        default: begin
          if (addr >= OFF_PRI0 && addr <= OFF_PRI7 && addr[1:0] == 2'h0) begin
            pri_reg = int'(addr - OFF_PRI0) / 4;
            for (int j = 0; j < PRI_PER_REG; j++) begin
              s_d.prio[pri_reg*PRI_PER_REG + j] = wdata[j*PRI_STRIDE +: PRIO_W];
            end
          end
        end
      endcase
    end
    // capture regardless of mask; a new event beats a same-cycle clear
    s_d.pend = (s_q.pend & ~clr) | event_in;
    // held enable follows the enable bit only while the channel is idle
    for (int k = 0; k < NUM_CH; k++) begin
      if (!s_q.pend[k]) begin
        s_d.held[k] = s_q.chen[k];
      end
    end
    s_d.fout   = |(s_q.pend & fast_ch & eff_en);
    s_d.nout   = |(s_q.pend & ~fast_ch & eff_en);
    s_d.fentry = f_entry_c;
    s_d.nentry = n_entry_c;
    // read data exists only in the cycle after the strobe; unmapped reads zero
    s_d.rdata = '0;
    if (rd) begin
      unique case (addr)
        OFF_FSTAT0: s_d.rdata = s_q.pend[HALF_CH-1:0] & fast_ch[HALF_CH-1:0];
        OFF_FSTAT1: s_d.rdata = s_q.pend[NUM_CH-1:HALF_CH] & fast_ch[NUM_CH-1:HALF_CH];
        OFF_NSTAT0: s_d.rdata = s_q.pend[HALF_CH-1:0] & ~fast_ch[HALF_CH-1:0];
        OFF_NSTAT1: s_d.rdata = s_q.pend[NUM_CH-1:HALF_CH] & ~fast_ch[NUM_CH-1:HALF_CH];
        OFF_FENTRY: s_d.rdata = f_entry_c;
        OFF_NENTRY: s_d.rdata = n_entry_c;
        OFF_EN0:    s_d.rdata = s_q.chen[HALF_CH-1:0];
        OFF_EN1:    s_d.rdata = s_q.chen[NUM_CH-1:HALF_CH];
        OFF_CTL: begin
          s_d.rdata[CTL_IDMODE]          = s_q.idmode;
          s_d.rdata[CTL_FRAW]            = s_q.fraw;
          s_d.rdata[CTL_NRAW]            = s_q.nraw;
          s_d.rdata[CTL_SIZE +: SIZE_W]  = s_q.size;
        end
        OFF_BASE:   s_d.rdata = s_q.base;
        default: begin
          if (addr >= OFF_PRI0 && addr <= OFF_PRI7 && addr[1:0] == 2'h0) begin
            pri_reg = int'(addr - OFF_PRI0) / 4;
            for (int j = 0; j < PRI_PER_REG; j++) begin
              s_d.rdata[j*PRI_STRIDE +: PRIO_W] = s_q.prio[pri_reg*PRI_PER_REG + j];
            end
          end
        end
      endcase
    end
  end

  // single state register; reset clears enables and outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata                 = s_q.rdata;
  assign fast_interrupt        = s_q.fout;
  assign normal_interrupt      = s_q.nout;
  assign fast_vector_address   = s_q.fentry;
  assign normal_vector_address = s_q.nentry;

  // checks on the outputs against their causes
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_capture_any_mask: assert property (
    (event_in != '0) |=> ((s_q.pend & $past(event_in)) == $past(event_in)))
    else $error("event not captured in status");

  a_zero_write_ignored: assert property (
    (wr && wdata == '0 && event_in == '0 && addr <= OFF_NSTAT1) |=> (s_q.pend == $past(s_q.pend)))
    else $error("zero write changed status");

  a_one_write_clears: assert property (
    (wr && addr == OFF_FSTAT0 && event_in == '0)
    |=> ((s_q.pend[HALF_CH-1:0] & $past(wdata) & $past(fast_ch[HALF_CH-1:0])) == '0))
    else $error("one write did not clear fast status");

  a_fast_out_level: assert property (
    (!s_q.idmode && |(s_q.pend & s_q.chen & fast_ch)) |=> fast_interrupt)
    else $error("fast output low with enabled fast request");

  a_masked_stays_low: assert property (
    (s_q.chen == '0 && s_q.held == '0) [*2] |-> (!fast_interrupt && !normal_interrupt))
    else $error("output high with every channel disabled");

  a_fast_winner_level: assert property (
    f_valid |-> (f_lvl <= LVL_FAST_MAX && s_q.prio[f_idx] == f_lvl && f_req[f_idx]
      && f_beat == '0))
    else $error("fast winner not at a fast level");

  a_norm_winner_level: assert property (
    n_valid |-> (n_lvl > LVL_FAST_MAX && n_req[n_idx] && s_q.prio[n_idx] == n_lvl
      && n_beat == '0))
    else $error("normal winner not the most urgent normal request");

  a_entry_idle_base: assert property (
    !f_valid ##1 !$changed(s_q.base) |-> (fast_vector_address == s_q.base))
    else $error("idle fast vector not equal to base");

  a_entry_formula: assert property (
    n_valid |=> (normal_vector_address ==
      $past(s_q.base) + ((DATA_W'($past(n_idx)) + 32'h0000_0001)
      << (ENTRY_SHIFT_MIN + int'($past(s_q.size))))))
    else $error("normal vector address wrong");

  a_read_base_next: assert property (
    (rd && addr == OFF_BASE) |=> (rdata == $past(s_q.base)) ##1 (rdata == '0 || $past(rd)))
    else $error("base register read back wrong");

  // reset, output levels, delayed enables and the status views
  a_reset_clears: assert property (
    disable iff (1'b0) !rstn |-> (!fast_interrupt && !normal_interrupt && s_q.chen == '0))
    else $error("outputs or enables not clear in reset");

  a_norm_out_level: assert property (
    (|(s_q.pend & ~fast_ch & eff_en)) |=> normal_interrupt)
    else $error("normal output low with enabled normal request");

  a_out_drops: assert property (
    (!(|(s_q.pend & eff_en))) |=> (!fast_interrupt && !normal_interrupt))
    else $error("output high with no enabled request");

  a_held_frozen: assert property (
    1'b1 |=> (((s_q.held ^ $past(s_q.held)) & $past(s_q.pend)) == '0))
    else $error("held enable changed while channel pending");

  a_status_routed: assert property (
    (rd && addr == OFF_FSTAT0)
    |=> (rdata == ($past(s_q.pend[HALF_CH-1:0]) & $past(fast_ch[HALF_CH-1:0]))))
    else $error("fast status view wrong");

  a_fast_vec_formula: assert property (
    f_valid |=> (fast_vector_address ==
      $past(s_q.base) + ((DATA_W'($past(f_idx)) + 32'h0000_0001)
      << (ENTRY_SHIFT_MIN + int'($past(s_q.size))))))
    else $error("fast vector address wrong");

  a_norm_idle_base: assert property (
    !n_valid ##1 !$changed(s_q.base) |-> (normal_vector_address == s_q.base))
    else $error("idle normal vector not equal to base");

  a_pri_readback: assert property (
    (rd && addr == OFF_PRI0) |=> (rdata[PRIO_W-1:0] == $past(s_q.prio[0])))
    else $error("priority register read back wrong");

  // main scenarios worth seeing at least once
  c_fast_raised:   cover property (!fast_interrupt ##1 fast_interrupt);
  c_normal_raised: cover property (!normal_interrupt ##1 normal_interrupt);
  c_set_beats_clr: cover property (wr && addr == OFF_NSTAT0 && (event_in[HALF_CH-1:0] & wdata) != '0);
  c_both_pending:  cover property (f_valid && n_valid);
  c_delayed_hold:  cover property (s_q.idmode && (s_q.pend & s_q.held & ~s_q.chen) != '0);
endmodule // core_irq_aggregator

// ### logic/core_irq_aggregator_pkg.sv
// constants shared by the interrupt aggregator and its winner selector
package core_irq_aggregator_pkg;
  // channel geometry
  localparam int NUM_CH    = 64;
  localparam int EXT_CH    = 16;
  localparam int IDX_W     = 6;
  localparam int PRIO_W    = 3;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int HALF_CH   = 32;
  // priority levels: 0..1 fast, 2..7 normal, lower value more urgent
  localparam logic [PRIO_W-1:0] LVL_FAST_MAX = 3'h1;
  // entry size code 0..3 selects 4, 8, 16 or 32 bytes
  localparam int ENTRY_SHIFT_MIN = 2;
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_FSTAT0  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FSTAT1  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_NSTAT0  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_NSTAT1  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_FENTRY  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_NENTRY  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EN0     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EN1     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_CTL     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_BASE    = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PRI0    = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_PRI7    = 8'h44;
  // priority registers: 8 channels each, 4-bit stride, 3 bits used
  localparam int PRI_PER_REG = 8;
  localparam int PRI_STRIDE  = 4;
  // control register field positions
  localparam int CTL_IDMODE = 0;
  localparam int CTL_FRAW   = 1;
  localparam int CTL_NRAW   = 2;
  localparam int CTL_SIZE   = 4;
  localparam int SIZE_W     = 2;
endpackage : core_irq_aggregator_pkg

// ### logic/prio_select.sv
// winner selector: most urgent level, lowest channel number on a tie
`timescale 1ns/1ps
module prio_select #(
  parameter int N  = 64,
  parameter int PW = 3,
  parameter int IW = 6
) (
  // candidates
  input  wire logic [N-1:0]    req,
  input  wire logic [N*PW-1:0] prio,
  // winner
  output logic                 valid,
  output logic [IW-1:0]        index,
  output logic [PW-1:0]        level
);
  // strict compare keeps the earlier, lower-numbered channel on equal level
  always_comb begin
    valid = 1'b0;
    index = '0;
    level = '1;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!valid || prio[i*PW +: PW] < level)) begin
        valid = 1'b1;
        index = IW'(i);
        level = prio[i*PW +: PW];
      end
    end
  end
endmodule // prio_select

// ### tb/core_side_model.sv
// core-side model: takes fast and normal interrupt levels like the core would
`timescale 1ns/1ps
module core_side_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // interrupt levels from the aggregator
  input  wire logic fast_interrupt,
  input  wire logic normal_interrupt,
  // entries taken so far
  output int        fast_taken,
  output int        normal_taken
);
  logic fast_q;
  logic normal_q;
  // one entry per rising level; the core never masks, so a wake-up is never lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fast_q       <= 1'b0;
      normal_q     <= 1'b0;
      fast_taken   <= 0;
      normal_taken <= 0;
    end else begin
      fast_q   <= fast_interrupt;
      normal_q <= normal_interrupt;
      if (fast_interrupt && !fast_q) fast_taken <= fast_taken + 1;
      if (normal_interrupt && !normal_q) normal_taken <= normal_taken + 1;
    end
  end
endmodule // core_side_model

// ### tb/tb_top.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t: mismatch got %h exp %h", $time, g, e); end end
module tb_top;
  import core_irq_aggregator_pkg::*;
  logic        clk, rstn, wr, rd;
  logic [63:0] event_in, pend_m, en_m, ev;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, fva, nva, base_m, d, q;
  logic        fi, ni, raw_m;
  int          fast_taken, normal_taken, err_total, cmp_count, seed, pri[64], size_m;
  core_irq_aggregator DUT (.clk(clk), .rstn(rstn), .event_in(event_in), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fast_interrupt(fi),
    .normal_interrupt(ni), .fast_vector_address(fva), .normal_vector_address(nva));
  core_side_model CORE (.clk(clk), .rstn(rstn), .fast_interrupt(fi),
    .normal_interrupt(ni), .fast_taken(fast_taken), .normal_taken(normal_taken));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one-cycle write, a gap cycle keeps each strobe assigned once per step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // routing mask of one type, by the current levels
  function automatic logic [63:0] route(input bit fast);
    for (int i = 0; i < 64; i++) route[i] = ((pri[i] <= 1) == fast);
  endfunction
  // expected entry: lowest level, then lowest channel; base when idle; raw counts disabled ones
  function automatic logic [31:0] exp_vec(input bit fast);
    int best, bl;
    best = -1; bl = 8;
    for (int i = 0; i < 64; i++)
      if (pend_m[i] && (raw_m || en_m[i]) && ((pri[i] <= 1) == fast) && pri[i] < bl) begin
        bl = pri[i]; best = i;
      end
    return (best < 0) ? base_m : base_m + (32'(best + 1) << (2 + size_m));
  endfunction
  // compare outputs, entries and status views with the model
  task automatic chk_all();
    logic [63:0] fm;
    fm = route(1);
    repeat (3) @(posedge clk);
    #1;
    `CHK(fi, |(pend_m & en_m & fm))
    `CHK(ni, |(pend_m & en_m & ~fm))
    `CHK(fva, exp_vec(1))
    `CHK(nva, exp_vec(0))
    rd_reg(OFF_FENTRY, d); `CHK(d, exp_vec(1))
    rd_reg(OFF_NENTRY, d); `CHK(d, exp_vec(0))
    rd_reg(OFF_FSTAT0, d); `CHK(d, pend_m[31:0] & fm[31:0])
    rd_reg(OFF_FSTAT1, d); `CHK(d, pend_m[63:32] & fm[63:32])
    rd_reg(OFF_NSTAT0, d); `CHK(d, pend_m[31:0] & ~fm[31:0])
    rd_reg(OFF_NSTAT1, d); `CHK(d, pend_m[63:32] & ~fm[63:32])
  endtask
  // write-one clear of all four status views; only bits of that type go
  task automatic clear_all(input logic [31:0] m);
    wr_reg(OFF_FSTAT0, m); wr_reg(OFF_FSTAT1, m); wr_reg(OFF_NSTAT0, m); wr_reg(OFF_NSTAT1, m);
    pend_m &= ~{m, m};
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard: a run past its bound counts as a mismatch
  initial begin
    #200us;
    err_total++;
    end_sim();
  end
  // main sequence
  initial begin
    seed = 84991; err_total = 0; cmp_count = 0;
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0; event_in = '0;
    pend_m = '0; en_m = '0; base_m = '0; size_m = 0; raw_m = 1'b0;
    foreach (pri[i]) pri[i] = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    #1 `CHK({fi, ni}, 2'h0)
    rd_reg(OFF_EN0, d); `CHK(d, 32'h0)
    rd_reg(8'hFC, d); `CHK(d, 32'h0)
    $display("reset test done");
    for (int t = 0; t < 4; t++) begin
      base_m = $random(seed) & 32'hFFFF_F000;
      size_m = t;
      wr_reg(OFF_BASE, base_m);
      wr_reg(OFF_CTL, 32'(t) << CTL_SIZE);
      rd_reg(OFF_BASE, q); `CHK(q, base_m)
      rd_reg(OFF_CTL, q); `CHK(q, 32'(t) << CTL_SIZE)
      for (int n = 0; n < 8; n++) begin
        d = '0;
        for (int j = 0; j < 8; j++) begin
          pri[8*n+j] = t[0] ? ($random(seed) & 1) + 6 * j[0] : $random(seed) & 7;
          d |= 32'(pri[8*n+j]) << (4 * j);
        end
        wr_reg(OFF_PRI0 + 8'(4 * n), d);
        rd_reg(OFF_PRI0 + 8'(4 * n), q); `CHK(q, d)
      end
      en_m = {$random(seed), $random(seed)};
      wr_reg(OFF_EN0, en_m[31:0]); wr_reg(OFF_EN1, en_m[63:32]);
      ev = {$random(seed), $random(seed)};
      @(posedge clk) event_in <= ev;
      @(posedge clk) event_in <= '0;
      pend_m |= ev;
      chk_all();
      clear_all(32'h0);
      chk_all();
      clear_all($random(seed));
      chk_all();
      en_m = '0;
      wr_reg(OFF_EN0, 32'h0); wr_reg(OFF_EN1, 32'h0);
      chk_all();
      clear_all(32'hFFFF_FFFF);
      chk_all();
      $display("size code %0d test done", t);
    end
    // delayed enables: a pending channel keeps the enable it was captured with
    size_m = 0;
    wr_reg(OFF_CTL, 32'h1 << CTL_IDMODE);
    en_m = '1;
    wr_reg(OFF_EN0, 32'hFFFF_FFFF); wr_reg(OFF_EN1, 32'hFFFF_FFFF);
    ev = {$random(seed), $random(seed)};
    @(posedge clk) event_in <= ev;
    @(posedge clk) event_in <= '0;
    pend_m |= ev;
    chk_all();
    wr_reg(OFF_EN0, 32'h0); wr_reg(OFF_EN1, 32'h0);
    chk_all();
    clear_all($random(seed));
    chk_all();
    // raw entries: disabled pending channels steer the vectors, never the outputs
    en_m = '0;
    raw_m = 1'b1;
    wr_reg(OFF_CTL, (32'h1 << CTL_FRAW) | (32'h1 << CTL_NRAW));
    chk_all();
    clear_all(32'hFFFF_FFFF);
    chk_all();
    $display("delayed and raw mode test done");
    `CHK(fast_taken > 0 && normal_taken > 0, 1'b1)
    end_sim();
  end
endmodule // tb_top
